// ===== serial_slave_param_commit_tb.sv
// Purpose: Self-checking bench for the serial slave commit block
// Assumes: Station address 11, default parameter depth
// Notes: Replies judged by length, key bytes and check-word residue
`timescale 1ns/1ps
module serial_slave_param_commit_tb;
  import sspc_pkg::*;
  typedef logic [7:0] sspc_bq_t[$];
  localparam logic [7:0] ST = 8'h11; // Own station
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic mode = 1'b0;
  logic fault = 1'b0;
  logic run = 1'b0;
  logic uv = 1'b0;
  logic nvb = 1'b0;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic bit_tick;
  logic nv_store_req;
  logic busy;
  sspc_rx_t rx;
  sspc_ctrl_t ctrl_out;
  sspc_ctrl_t last_ctrl = '0; // Latest control pulse content
  int err_total = 0;
  int checks = 0;
  int stores = 0;
  int ctrls = 0;
  always #50 clk = ~clk;
  // Count the one-cycle pulses
  always @(posedge clk) begin
    if (nv_store_req === 1'b1) stores++;
    if (ctrl_out.valid === 1'b1) begin
      ctrls++;
      last_ctrl <= ctrl_out;
    end
  end
  sspc_core i_sspc_core (.clk(clk), .ce(1'b1), .reset_n(reset_n), .rx(rx),
    .bit_tick(bit_tick), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .station_address_setting(ST), .commit_requirement_select(mode),
    .stored_data_fault(fault), .drive_running(run), .dc_undervoltage(uv),
    .nv_busy(nvb), .nv_store_req(nv_store_req), .ctrl_out(ctrl_out), .busy(busy));
  sspc_plc_model i_sspc_plc_model (.clk(clk), .rx(rx), .bit_tick(bit_tick),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic sspc_bq_t wr(input logic [7:0] a, input logic [15:0] r, input logic [15:0] v);
    return '{a, 8'h10, r[15:8], r[7:0], 8'h00, 8'h01, 8'h02, v[15:8], v[7:0]};
  endfunction
  // Two-word write to the first parameter pair
  function automatic sspc_bq_t wr2(input logic [15:0] v0, input logic [15:0] v1);
    return '{ST, 8'h10, 8'h01, 8'h00, 8'h00, 8'h02, 8'h04, v0[15:8], v0[7:0], v1[15:8], v1[7:0]};
  endfunction
  // Fixed wait covers the 24-bit end gap, then a bounded wait on busy
  task automatic go(input sspc_bq_t m, input logic bad, input int n);
    i_sspc_plc_model.send(m, bad);
    repeat (120) @(posedge clk);
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(16'(i_sspc_plc_model.resp.size()), 16'(n));
    if (n > 0) chk(i_sspc_plc_model.fcs(i_sspc_plc_model.resp), 16'h0000);
  endtask
  task automatic exc(input sspc_bq_t m, input logic [7:0] code);
    go(m, 1'b0, 5);
    chk({i_sspc_plc_model.resp[1], i_sspc_plc_model.resp[2]}, {m[1] | 8'h80, code});
  endtask
  // Single-word read; the answer shows the live image
  task automatic rd(input logic [15:0] a, input logic [15:0] v);
    go('{ST, 8'h03, a[15:8], a[7:0], 8'h00, 8'h01}, 1'b0, 7);
    chk({i_sspc_plc_model.resp[3], i_sspc_plc_model.resp[4]}, v);
  endtask
  task automatic t_errors;
    exc('{ST, 8'h03, 8'h09, 8'h00, 8'h00, 8'h01}, EX_ADDR);
    exc('{ST, 8'h03, 8'h09, 8'h10, 8'h00, 8'h01}, EX_ADDR);
    exc('{ST, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00}, EX_FUNC);
    // Diagnostic echo is a served function
    go('{ST, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 1'b0, 8);
    chk({i_sspc_plc_model.resp[4], i_sspc_plc_model.resp[5]}, 16'h1234);
    exc('{ST, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02},
        EX_COUNT);
    exc(wr(ST, 16'h0010, 16'h0001), EX_MODE);
    run <= 1'b1;
    exc(wr(ST, 16'h0120, 16'h0001), EX_MODE);
    run <= 1'b0;
    fault <= 1'b1;
    exc(wr(ST, 16'h0106, 16'h0001), EX_MODE);
    fault <= 1'b0;
    uv <= 1'b1;
    exc(wr(ST, 16'h0130, 16'h0001), EX_UV);
    uv <= 1'b0;
    nvb <= 1'b1;
    exc(wr(ST, 16'h0001, 16'h0001), EX_BUSY);
    nvb <= 1'b0;
    // Status word shows the exception code of the last answered message
    rd(16'h0010, 16'h0024);
  endtask
  task automatic t_commit;
    // Mode one: live at once, partner back to its default
    mode <= 1'b1;
    go(wr(ST, 16'h0100, 16'h0005), 1'b0, 8);
    rd(16'h0100, 16'h0005);
    rd(16'h0101, 16'h0000);
    // Mode zero: held until a commit; related check drops the word that breaks its pair
    mode <= 1'b0;
    go(wr(ST, 16'h0101, 16'h0009), 1'b0, 8);
    rd(16'h0101, 16'h0000);
    go(wr(ST, 16'h0100, 16'h000a), 1'b0, 8);
    go(wr(ST, 16'h0900, 16'h0000), 1'b0, 8);
    chk(16'(stores), 16'h0001);
    rd(16'h0101, 16'h0009);
    rd(16'h0100, 16'h0005);
    go(wr(ST, 16'h0910, 16'h0000), 1'b0, 8);
    chk(16'(stores), 16'h0001);
  endtask
  task automatic t_mode;
    // Second word out of limits: mode zero keeps the first only
    go(wr2(16'h0003, 16'h8000), 1'b0, 8);
    go(wr(ST, 16'h0910, 16'h0000), 1'b0, 8);
    rd(16'h0100, 16'h0003);
    rd(16'h0101, 16'h0009);
    // Mode one throws the good word away as well
    mode <= 1'b1;
    exc(wr2(16'h0007, 16'h8000), EX_DATA);
    rd(16'h0100, 16'h0003);
    mode <= 1'b0;
  endtask
  task automatic t_silent;
    i_sspc_plc_model.slow <= 1'b1;
    go(wr(ST, 16'h0001, 16'h1234), 1'b0, 8);
    i_sspc_plc_model.slow <= 1'b0;
    chk({last_ctrl.addr, last_ctrl.data}, {5'h01, 16'h1234});
    rd(16'h0001, 16'h1234);
    go(wr(8'h00, 16'h0002, 16'h00a5), 1'b0, 0);
    chk(16'(ctrls), 16'h0002);
    chk({last_ctrl.addr, last_ctrl.data}, {5'h02, 16'h00a5});
    go(wr(8'h00, 16'h0003, 16'h0001), 1'b0, 0);
    go(wr(8'h22, 16'h0001, 16'h0001), 1'b0, 0);
    go(wr(ST, 16'h0001, 16'h0001), 1'b1, 0);
    chk(16'(ctrls), 16'h0002);
  endtask
  task automatic test_done;
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_errors();
    t_commit();
    t_mode();
    t_silent();
    test_done();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule

// ===== sspc_core.sv
// Purpose: Serial register-access slave with parameter commit handling
// Assumes: Receiver delivers bytes with a line error flag and a bit-time tick
// Notes: A gap above the limit ends the message; incomplete ones are dropped
`timescale 1ns/1ps
module sspc_core #(
  parameter int MAXW = 16,
  parameter int PDEPTH = 64
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic reset_n,
  input wire sspc_pkg::sspc_rx_t rx,
  input wire logic bit_tick,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] station_address_setting,
  input wire logic commit_requirement_select,
  input wire logic stored_data_fault,
  input wire logic drive_running,
  input wire logic dc_undervoltage,
  input wire logic nv_busy,
  output logic nv_store_req,
  output sspc_pkg::sspc_ctrl_t ctrl_out,
  output logic busy
);
  import sspc_pkg::*;

  localparam int BW = $clog2(MAXW + 1);
  localparam int AW = $clog2(IDX_PAR + PDEPTH + 1);

  sspc_state_t st_ff; // Main sequencer state
  logic [7:0] hdr_ff [0:6]; // Address, function, start, count, byte count
  logic [5:0] cnt_ff; // Bytes received in this message
  logic [15:0] crc_ff; // Running CRC over received bytes
  logic drop_ff; // Message already condemned
  logic [4:0] gap_ff; // Bit times since last byte
  logic [7:0] hi_ff; // Previous byte, high half of a data word
  logic bcast_ff; // Message was a broadcast
  logic [7:0] ex_ff; // Pending exception code
  logic [7:0] last_ex_ff; // Exception of the last answered message
  logic [BW-1:0] widx_ff; // Word index in check and write loops
  logic [1:0] phase_ff; // Per-word step
  logic [AW-1:0] copy_ff; // Commit copy read index
  logic [AW-1:0] copy_wa_ff; // Commit copy write index
  logic copy_v_ff; // Copy write pending
  logic [5:0] tidx_ff; // Response byte index
  logic ld_ff; // Response byte being fetched
  logic [15:0] tcrc_ff; // Response CRC

  // Field views of the header
  wire [7:0] func = hdr_ff[1];
  wire [15:0] start = {hdr_ff[2], hdr_ff[3]};
  wire [15:0] qty = {hdr_ff[4], hdr_ff[5]};
  wire [7:0] bcnt = hdr_ff[6];
  wire rx_take = rx.valid && (st_ff == ST_RX);
  wire gap_end = (st_ff == ST_RX) && bit_tick && (cnt_ff != 6'h00) && (gap_ff == GAP_BITS);
  wire is_wr = (func == FC_WRITE);

  // Memory port wires
  logic [15:0] buf_rdata, pend_rdata, act_rdata;
  logic pend_we, act_we;
  logic [AW-1:0] pend_waddr, pend_raddr, act_waddr, act_raddr;
  logic [15:0] pend_wdata, act_wdata;

  // Map a register number onto a parameter image index
  function automatic logic [AW-1:0] to_idx(input logic [15:0] a);
    logic [15:0] o;
    o = (a <= IMM_LAST) ? a : (a - PARAM_BASE + 16'(IDX_PAR));
    return o[AW-1:0];
  endfunction

  // Gap timer counts bit times of silence inside a message
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gap_ff <= 5'h00;
    end else if (ce) begin
      if (rx_take || gap_end) begin
        gap_ff <= 5'h00;
      end else if (bit_tick && cnt_ff != 6'h00 && gap_ff != GAP_BITS) begin
        gap_ff <= gap_ff + 5'h01;
      end
    end
  end

  // Byte collection; header bytes kept in flops, data words go to the buffer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_ff <= 6'h00;
      crc_ff <= CRC_INIT;
      drop_ff <= 1'b0;
      hi_ff <= 8'h00;
      for (int i = 0; i < 7; i++) begin
        hdr_ff[i] <= 8'h00;
      end
    end else if (ce) begin
      if (gap_end) begin
        cnt_ff <= 6'h00;
        crc_ff <= CRC_INIT;
        drop_ff <= 1'b0;
      end else if (rx_take) begin
        cnt_ff <= (cnt_ff == 6'h3f) ? cnt_ff : cnt_ff + 6'h01;
        crc_ff <= sspc_crc(crc_ff, rx.data);
        hi_ff <= rx.data;
        if (rx.err || cnt_ff == 6'h3f) begin
          drop_ff <= 1'b1;
        end
        if (cnt_ff < 6'h07) begin
          hdr_ff[cnt_ff[2:0]] <= rx.data;
        end
      end
    end
  end

  // Buffer write on each low data byte; bytes beyond MAXW words are dropped
  wire [5:0] woff = cnt_ff - 6'h08;
  wire buf_we = rx_take && (cnt_ff >= 6'h08) && !cnt_ff[0] && ({1'b0, woff[5:1]} < 6'(MAXW));

  // Length expected from the function code
  logic len_ok;
  always_comb begin
    if (func == FC_READ || func == FC_DIAG) begin
      len_ok = (cnt_ff == 6'h08);
    end else if (is_wr) begin
      len_ok = ({3'h0, cnt_ff} == ({1'b0, bcnt} + 9'h009));
    end else begin
      len_ok = (cnt_ff >= 6'h04);
    end
  end

  wire frame_go = gap_end && !drop_ff && (crc_ff == CRC_RESIDUE) && len_ok &&
                  (hdr_ff[0] == station_address_setting || hdr_ff[0] == BCAST_ADDR);

  // Header classification
  wire [16:0] last_a = {1'b0, start} + {1'b0, qty} - 17'h00001;
  wire is_imm = last_a <= {1'b0, IMM_LAST};
  wire is_par = (start >= PARAM_BASE) && (last_a < ({1'b0, PARAM_BASE} + 17'(PDEPTH)));
  wire is_cmt = (qty == 16'h0001) && (start == REG_COMMIT_NV || start == REG_COMMIT_WM);
  wire qty_bad = (qty == 16'h0000) || (qty > 16'(MAXW));

  // Header checks in priority order
  logic [7:0] hdr_ex;
  always_comb begin
    hdr_ex = EX_NONE;
    if (func != FC_READ && func != FC_DIAG && !is_wr) begin
      hdr_ex = EX_FUNC;
    end else if (func == FC_DIAG) begin
      hdr_ex = (start == DIAG_ECHO) ? EX_NONE : EX_FUNC;
    end else if (qty_bad || (is_wr && {8'h00, bcnt} != {qty[14:0], 1'b0})) begin
      hdr_ex = EX_COUNT;
    end else if (bcast_ff && !(is_wr && start >= BCAST_LO && last_a <= {1'b0, BCAST_HI})) begin
      hdr_ex = EX_ADDR;
    end else if (!(is_imm || is_par || (is_cmt && is_wr))) begin
      hdr_ex = EX_ADDR;
    end else if (is_wr && nv_busy) begin
      hdr_ex = EX_BUSY;
    end
  end

  // Per-word classification during check and write loops
  wire [15:0] cur_a = start + 16'(widx_ff);
  wire last_word = (16'(widx_ff) == qty - 16'h0001);
  wire w_imm = cur_a <= IMM_LAST;
  wire w_stat = w_imm && (cur_a >= STAT_BASE);
  wire w_par = !w_imm && !is_cmt;
  wire mode1 = commit_requirement_select;
  wire in_lim = (buf_rdata >= LIM_LO) && (buf_rdata <= LIM_HI);
  // mode zero pairs even low with odd high bound
  wire rel_ok = cur_a[0] ? (buf_rdata >= pend_rdata) : (buf_rdata <= pend_rdata);
  // mode zero keeps only good values
  wire wr_ok = w_imm || (w_par && in_lim && (mode1 || rel_ok));

  // Word checks that refuse the whole message
  logic [7:0] chk_ex;
  always_comb begin
    chk_ex = EX_NONE;
    if (w_stat || (w_par && drive_running && cur_a >= RUN_LOCK_BASE) ||
        (w_par && stored_data_fault && cur_a > FAULT_OK_HI)) begin
      chk_ex = EX_MODE;
    end else if (w_par && dc_undervoltage && cur_a >= UV_LOCK_BASE) begin
      chk_ex = EX_UV;
    end else if ((w_par && mode1 && !in_lim) || (is_cmt && buf_rdata != COMMIT_VALUE)) begin
      chk_ex = EX_DATA;
    end
  end

  // Response length and fetch address
  wire [5:0] resp_len = (ex_ff != EX_NONE) ? 6'h05 :
                        (func == FC_READ) ? (6'h05 + {qty[4:0], 1'b0}) : 6'h08;
  wire [5:0] toff = tidx_ff - 6'h03;
  wire [15:0] rd_a = start + {11'h000, toff[5:1]};

  // Memory port steering
  always_comb begin
    pend_we = 1'b0;
    act_we = 1'b0;
    pend_waddr = to_idx(cur_a);
    pend_wdata = buf_rdata;
    pend_raddr = to_idx(cur_a ^ 16'h0001);
    act_waddr = to_idx(cur_a);
    act_wdata = buf_rdata;
    act_raddr = to_idx(rd_a);
    if (st_ff == ST_WR && phase_ff == 2'h1 && !is_cmt && wr_ok) begin
      pend_we = 1'b1;
      act_we = w_imm || mode1;
    end else if (st_ff == ST_WR && phase_ff == 2'h2) begin
      pend_we = 1'b1;
      act_we = 1'b1;
      pend_waddr = to_idx(cur_a ^ 16'h0001);
      act_waddr = to_idx(cur_a ^ 16'h0001);
      pend_wdata = REL_DEFAULT;
      act_wdata = REL_DEFAULT;
    end else if (st_ff == ST_COPY) begin
      pend_raddr = copy_ff;
      act_we = copy_v_ff;
      act_waddr = copy_wa_ff;
      act_wdata = pend_rdata;
    end
  end

  wire copy_end = (copy_ff == AW'(IDX_PAR + PDEPTH));
  wire tx_done = tx_valid && tx_ready && (tidx_ff == resp_len - 6'h01);

  // Main sequencer with the word loops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_ff <= ST_RX;
      widx_ff <= '0;
      phase_ff <= 2'h0;
      ex_ff <= EX_NONE;
      last_ex_ff <= EX_NONE;
      bcast_ff <= 1'b0;
    end else if (ce) begin
      case (st_ff)
        ST_RX: begin
          if (frame_go) begin
            st_ff <= ST_HDR;
            ex_ff <= EX_NONE;
            widx_ff <= '0;
            phase_ff <= 2'h0;
            bcast_ff <= (hdr_ff[0] == BCAST_ADDR);
          end
        end
        ST_HDR: begin
          if (hdr_ex != EX_NONE || !is_wr) begin
            ex_ff <= hdr_ex;
            st_ff <= bcast_ff ? ST_RX : ST_RESP;
          end else begin
            st_ff <= ST_CHK;
          end
        end
        ST_CHK: begin
          if (phase_ff == 2'h0) begin
            phase_ff <= 2'h1;
          end else if (chk_ex != EX_NONE) begin
            ex_ff <= chk_ex;
            st_ff <= bcast_ff ? ST_RX : ST_RESP;
          end else begin
            phase_ff <= 2'h0;
            widx_ff <= last_word ? '0 : widx_ff + BW'(1);
            st_ff <= last_word ? ST_WR : ST_CHK;
          end
        end
        ST_WR: begin
          if (phase_ff == 2'h0) begin
            phase_ff <= 2'h1;
          end else if (phase_ff == 2'h1 && is_cmt) begin
            st_ff <= ST_COPY;
          end else if (phase_ff == 2'h1 && mode1 && w_par && wr_ok) begin
            phase_ff <= 2'h2;
          end else if (last_word) begin
            st_ff <= bcast_ff ? ST_RX : ST_RESP;
          end else begin
            phase_ff <= 2'h0;
            widx_ff <= widx_ff + BW'(1);
          end
        end
        ST_COPY: begin
          if (copy_end && !copy_v_ff) begin
            st_ff <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (tx_done) begin
            st_ff <= ST_RX;
            last_ex_ff <= ex_ff;
          end
        end
        default: begin
          st_ff <= ST_RX;
        end
      endcase
    end
  end

  // Commit copy walks the parameter image; control words are already live
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      copy_ff <= '0;
      copy_wa_ff <= '0;
      copy_v_ff <= 1'b0;
      nv_store_req <= 1'b0;
    end else if (ce) begin
      nv_store_req <= (st_ff == ST_WR) && (phase_ff == 2'h1) && is_cmt &&
                      (start == REG_COMMIT_NV);
      if (st_ff != ST_COPY) begin
        copy_ff <= AW'(IDX_PAR);
        copy_v_ff <= 1'b0;
      end else begin
        copy_v_ff <= !copy_end;
        copy_wa_ff <= copy_ff;
        if (!copy_end) begin
          copy_ff <= copy_ff + AW'(1);
        end
      end
    end
  end

  // Immediate control word updates for the drive
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_out <= '0;
    end else if (ce) begin
      ctrl_out.valid <= act_we && (st_ff == ST_WR) && w_imm;
      ctrl_out.addr <= cur_a[4:0];
      ctrl_out.data <= buf_rdata;
    end
  end

  // Response byte selection; the status word shows the last exception
  logic [7:0] tbyte;
  logic [15:0] rword;
  always_comb begin
    rword = (rd_a == STATUS_REG) ? {8'h00, last_ex_ff} : act_rdata;
    tbyte = 8'h00;
    if (tidx_ff == resp_len - 6'h02) begin
      tbyte = tcrc_ff[7:0];
    end else if (tidx_ff == resp_len - 6'h01) begin
      tbyte = tcrc_ff[15:8];
    end else if (tidx_ff == 6'h00) begin
      tbyte = hdr_ff[0];
    end else if (ex_ff != EX_NONE) begin
      tbyte = (tidx_ff == 6'h01) ? (func | FC_EXC_FLAG) : ex_ff;
    end else if (func == FC_READ) begin
      if (tidx_ff == 6'h01) begin
        tbyte = func;
      end else if (tidx_ff == 6'h02) begin
        tbyte = {qty[6:0], 1'b0};
      end else begin
        tbyte = toff[0] ? rword[7:0] : rword[15:8];
      end
    end else if (tidx_ff < 6'h06) begin
      tbyte = hdr_ff[tidx_ff[2:0]];
    end
  end

  // Response sender: fetch one cycle, then offer the byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tidx_ff <= 6'h00;
      ld_ff <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tcrc_ff <= CRC_INIT;
    end else if (ce) begin
      if (st_ff != ST_RESP) begin
        tidx_ff <= 6'h00;
        ld_ff <= 1'b0;
        tx_valid <= 1'b0;
        tcrc_ff <= CRC_INIT;
      end else if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
        tidx_ff <= tidx_ff + 6'h01;
      end else if (!tx_valid && !ld_ff) begin
        ld_ff <= 1'b1;
      end else if (ld_ff) begin
        ld_ff <= 1'b0;
        tx_valid <= 1'b1;
        tx_data <= tbyte;
        if (tidx_ff < resp_len - 6'h02) begin
          tcrc_ff <= sspc_crc(tcrc_ff, tbyte);
        end
      end
    end
  end

  assign busy = (st_ff != ST_RX);

  // Message buffer and the two parameter images
  sspc_mem #(.DW(16), .AW(BW)) u_buf (.clk(clk), .ce(ce), .we(buf_we),
    .waddr(woff[BW:1]), .wdata({hi_ff, rx.data}), .raddr(widx_ff), .rdata(buf_rdata));
  sspc_mem #(.DW(16), .AW(AW)) u_pend (.clk(clk), .ce(ce), .we(pend_we),
    .waddr(pend_waddr), .wdata(pend_wdata), .raddr(pend_raddr), .rdata(pend_rdata));
  sspc_mem #(.DW(16), .AW(AW)) u_act (.clk(clk), .ce(ce), .we(act_we),
    .waddr(act_waddr), .wdata(act_wdata), .raddr(act_raddr), .rdata(act_rdata));

  // Checks on the sequencer and the answers
  a_nv_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    nv_store_req |=> !nv_store_req ##1 (st_ff == ST_COPY))
    else $error("nonvolatile store request not a single pulse into copy");
  a_wm_no_store: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == ST_COPY && start == REG_COMMIT_WM) |-> !nv_store_req)
    else $error("working commit raised nonvolatile store");
  a_commit_read: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == ST_RESP && func == FC_READ && start == REG_COMMIT_NV) |-> ex_ff == EX_ADDR)
    else $error("read of commit word not refused with 02");
  a_ctrl_now: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && st_ff == ST_WR && phase_ff == 2'h1 && w_imm && !is_cmt) |=>
      (ctrl_out.valid && ctrl_out.data == $past(buf_rdata)))
    else $error("control write not passed on at once");
  a_mode0_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == ST_WR && !mode1 && w_par) |-> !act_we)
    else $error("mode zero parameter activated without commit");
  a_func_ex: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == ST_RESP && func != FC_READ && func != FC_DIAG && !is_wr) |-> ex_ff == EX_FUNC)
    else $error("unsupported function not answered with 01");
  a_gap_bound: assert property (@(posedge clk) disable iff (!reset_n)
    (gap_ff <= GAP_BITS) and (gap_end |=> cnt_ff == 6'h00))
    else $error("gap limit not enforced");
  a_bcast_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (bcast_ff && st_ff != ST_RX) |-> !tx_valid)
    else $error("broadcast produced a response");
  a_err_drop: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && rx_take && rx.err && !gap_end) |=> (drop_ff || cnt_ff == 6'h00))
    else $error("line error did not condemn message");
endmodule

// ===== sspc_mem.sv
// Purpose: Small word memory with one write port and a registered read port
// Assumes: No reset; contents are undefined until written
// Notes: Used for the message buffer and both parameter images
`timescale 1ns/1ps
module sspc_mem #(
  parameter int DW = 16,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  // Storage array
  logic [DW-1:0] ram_ff [0:(1<<AW)-1];

  // Write port; read data lands one edge later
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        ram_ff[waddr] <= wdata;
      end
      rdata <= ram_ff[raddr];
    end
  end
endmodule

// ===== sspc_pkg.sv
// Purpose: Shared constants, types and CRC helper for the serial slave commit block
// Assumes: Register numbers, exception codes and limits are fixed per product build
// Notes: Region boundaries other than the commit words are build choices
package sspc_pkg;
  // Function codes served
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WRITE = 8'h10;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [15:0] DIAG_ECHO = 16'h0000;
  // Exception codes
  localparam logic [7:0] EX_NONE = 8'h00;
  localparam logic [7:0] EX_FUNC = 8'h01;
  localparam logic [7:0] EX_ADDR = 8'h02;
  localparam logic [7:0] EX_COUNT = 8'h03;
  localparam logic [7:0] EX_DATA = 8'h21;
  localparam logic [7:0] EX_MODE = 8'h22;
  localparam logic [7:0] EX_UV = 8'h23;
  localparam logic [7:0] EX_BUSY = 8'h24;
  // Register map
  localparam logic [15:0] REG_COMMIT_NV = 16'h0900;
  localparam logic [15:0] REG_COMMIT_WM = 16'h0910;
  localparam logic [15:0] COMMIT_VALUE = 16'h0000;
  localparam logic [15:0] STAT_BASE = 16'h0010;
  localparam logic [15:0] STATUS_REG = 16'h0010;
  localparam logic [15:0] IMM_LAST = 16'h001f;
  localparam logic [15:0] BCAST_LO = 16'h0001;
  localparam logic [15:0] BCAST_HI = 16'h0002;
  localparam logic [15:0] PARAM_BASE = 16'h0100;
  localparam logic [15:0] RUN_LOCK_BASE = 16'h0120;
  localparam logic [15:0] UV_LOCK_BASE = 16'h0130;
  localparam logic [15:0] FAULT_OK_HI = 16'h0105;
  localparam int IDX_PAR = 32;
  // Parameter limits and the default given to a related parameter
  localparam logic [15:0] LIM_LO = 16'h0000;
  localparam logic [15:0] LIM_HI = 16'h7fff;
  localparam logic [15:0] REL_DEFAULT = 16'h0000;
  // Framing
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [4:0] GAP_BITS = 5'h18;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  // Received byte from the serial receiver
  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] data;
  } sspc_rx_t;

  // Immediate control word update
  typedef struct packed {
    logic valid;
    logic [4:0] addr;
    logic [15:0] data;
  } sspc_ctrl_t;

  typedef enum logic [5:0] {
    ST_RX = 6'b000001,
    ST_HDR = 6'b000010,
    ST_CHK = 6'b000100,
    ST_WR = 6'b001000,
    ST_COPY = 6'b010000,
    ST_RESP = 6'b100000
  } sspc_state_t;

  // Reflected CRC-16 step over one byte
  function automatic logic [15:0] sspc_crc(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ===== sspc_plc_model.sv
// Purpose: Serial master model that frames requests and gathers replies
// Assumes: Bit time of four clocks; one byte strobe per frame byte
// Notes: Slow mode drops ready on every other clock to exercise the hold rule
`timescale 1ns/1ps
module sspc_plc_model (
  input wire logic clk,
  output sspc_pkg::sspc_rx_t rx,
  output logic bit_tick,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  import sspc_pkg::*;
  logic [1:0] tick_cnt = 2'h0; // Divides the clock into bit times
  logic slow = 1'b0; // Set by the bench to stall replies
  logic [7:0] resp[$]; // Reply bytes in arrival order
  initial begin
    rx = '0;
    bit_tick = 1'b0;
    tx_ready = 1'b0;
  end
  // Bit time pulses and reply capture
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    bit_tick <= (tick_cnt == 2'h3);
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      resp.push_back(tx_data);
    end
  end
  // Reflected check word; kept separate from the block's own helper
  function automatic logic [15:0] fcs(input logic [7:0] m[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (m[i]) begin
      c ^= {8'h00, m[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  task automatic send(input logic [7:0] m[$], input logic bad);
    logic [15:0] c;
    c = fcs(m);
    m.push_back(c[7:0]);
    m.push_back(c[15:8]);
    resp.delete();
    foreach (m[i]) begin
      @(posedge clk);
      rx <= '{1'b1, bad && (i == 1), m[i]};
      @(posedge clk);
      rx <= '0;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule
